// [hw/dmsr_pkg.sv]
package dmsr_pkg;
    // Matrix geometry
    localparam int ROWS = 7;
    localparam int COLS = 5;
    localparam int PKG_CHARS = 4;
    localparam int HALF_STAGES = 14;
    localparam int PKG_STAGES = 28;
    localparam int CODE_W = 7;
    localparam int ROW_W = 3;
    localparam int FONT_DEPTH = 128;
    localparam logic [2:0] ROW_TOP = 3'h6;
    localparam logic [2:0] COL_LAST = 3'h4;
    // Timing
    localparam int CLK_NS = 50;
    localparam int SCLK_NS = 400;
    localparam int SCLK_HALF = SCLK_NS / (2 * CLK_NS);
    localparam int REFRESH_MS_MAX = 10;
    localparam int REFRESH_CYC_MAX = REFRESH_MS_MAX * 1000000 / CLK_NS;
    localparam int LOAD_M = 16;
    localparam int DIM_W = 16;
    // Buffering
    localparam int FIFO_DEPTH = 16;
    // Controller states
    typedef enum logic [2:0] {
        DMSR_LOAD = 3'h1,
        DMSR_SHOW = 3'h2,
        DMSR_DIM = 3'h4
    } dmsr_state_e;
endpackage

// [hw/dmsr_link_if.sv]
`timescale 1ns/100ps
interface dmsr_link_if;
    logic sclk;
    logic sdi;
    logic blank_n;
    logic [4:0] col;
    logic sdo;
    modport ctrl (output sclk, output sdi, output blank_n, output col,
        input sdo);
    modport disp (input sclk, input sdi, input blank_n, input col,
        output sdo);
endinterface

// [hw/dmsr_fifo.sv]
`timescale 1ns/100ps
module dmsr_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = dmsr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } dmsr_fifo_s;
    dmsr_fifo_s q, d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign in_ready_out = (q.cnt != (PW+1)'(DEPTH));
    assign out_valid_out = (q.cnt != '0);
    assign out_data_out = mem[q.rp];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always_comb
    begin
        d = q;
        if (push)
            d.wp = q.wp + 1'b1;
        if (pop)
            d.rp = q.rp + 1'b1;
        if (push & ~pop)
            d.cnt = q.cnt + 1'b1;
        else if (pop & ~push)
            d.cnt = q.cnt - 1'b1;
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            q <= '0;
        else if (ce_in)
            q <= d;
    end

    // Storage needs no reset; only counted words are ever read
    always_ff @(posedge clk_in)
    begin
        if (ce_in & push)
            mem[q.wp] <= in_data_in;
    end
endmodule

// [hw/dmsr_display.sv]
`timescale 1ns/100ps
module dmsr_display #(
    parameter int PACKAGES = 1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // Link
    dmsr_link_if.disp link,
    // Row sinks and lit dots
    output logic [PACKAGES*dmsr_pkg::PKG_STAGES-1:0] row_sink_out,
    output logic [PACKAGES*dmsr_pkg::PKG_CHARS*35-1:0] led_out
);
    localparam int STAGES = PACKAGES * dmsr_pkg::PKG_STAGES;
    localparam int CHARS = PACKAGES * dmsr_pkg::PKG_CHARS;
    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic sdi_s1;
        logic sdi_s2;
        logic blank_s1;
        logic blank_s2;
        logic [4:0] col_s1;
        logic [4:0] col_s2;
        logic [STAGES-1:0] sr;
        logic sdo;
        logic [STAGES-1:0] sink;
        logic [CHARS*35-1:0] led;
    } dmsr_disp_s;
    dmsr_disp_s q, d;

    always_comb
    begin
        d = q;
        d.sclk_s1 = link.sclk;
        d.sclk_s2 = q.sclk_s1;
        d.sclk_s3 = q.sclk_s2;
        d.sdi_s1 = link.sdi;
        d.sdi_s2 = q.sdi_s1;
        d.blank_s1 = link.blank_n;
        d.blank_s2 = q.blank_s1;
        d.col_s1 = link.col;
        d.col_s2 = q.col_s1;
        // Shift on falling shift clock, stage 0 is leftmost row 1
        if (q.sclk_s3 & ~q.sclk_s2)
            d.sr = {q.sr[STAGES-2:0], q.sdi_s2};
        // Packages chain end to end: each last stage feeds the next
        d.sdo = d.sr[STAGES-1];
        d.sink = d.sr & {STAGES{q.blank_s2}};
        for (int c = 0; c < CHARS; c++)
        begin
            for (int k = 0; k < dmsr_pkg::COLS; k++)
            begin
                for (int r = 0; r < dmsr_pkg::ROWS; r++)
                begin
                    // Each column pin feeds that column of every char
                    d.led[c*35 + k*7 + r] =
                        q.sink[c*7 + r] & q.col_s2[k];
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            q <= '0;
        else if (ce_in)
            q <= d;
    end

    assign link.sdo = q.sdo;
    assign row_sink_out = q.sink;
    assign led_out = q.led;
endmodule

// [hw/dmsr_ctrl.sv]
`timescale 1ns/100ps
// Operation
// - Display shifts data on falling clock
// - Two 14-bit stages chain to 28
// - Seven consecutive stages drive each character
// - Sink on only with bit and blanking
// - Dot lit when sink and column on
// - Like columns of characters share input
// - Column current off while shifting data
// - Serial output is the last stage
// - Serial output feeds next package input
// - First bit ends in rightmost character
// - Every dot refreshed 100 times per second
// - Load column subset, show, next column
// - Optional blanked interval before each load
// - Rightmost character symbol decoded first
// - Font maps code and row to columns
// - Rows delivered seven down to one
// - One load count, M-1 display counts
// - Modulo-five counter selects data and driver
module dmsr_ctrl #(
    parameter int CHARS = dmsr_pkg::PKG_CHARS,
    parameter int LOAD_M = dmsr_pkg::LOAD_M,
    parameter int HALF = dmsr_pkg::SCLK_HALF
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // Symbol writes, buffered
    input wire logic sym_valid_in,
    output logic sym_ready_out,
    input wire logic [$clog2(CHARS)-1:0] sym_addr_in,
    input wire logic [dmsr_pkg::CODE_W-1:0] sym_code_in,
    // Font table writes
    input wire logic font_wr_in,
    input wire logic [dmsr_pkg::CODE_W-1:0] font_code_in,
    input wire logic [dmsr_pkg::ROW_W-1:0] font_row_in,
    input wire logic [dmsr_pkg::COLS-1:0] font_bits_in,
    // Dimming, blanked cycles before each load
    input wire logic [dmsr_pkg::DIM_W-1:0] dim_cycles_in,
    // Status
    output logic loading_out,
    output logic [2:0] column_out,
    // Link
    dmsr_link_if.ctrl link
);
    localparam int AW = $clog2(CHARS);
    localparam int FW = AW + dmsr_pkg::CODE_W;
    localparam int LOAD_CYC = CHARS * dmsr_pkg::ROWS * 2 * HALF;
    localparam int SHOW_CYC = (LOAD_M - 1) * LOAD_CYC;
    localparam int TW = $clog2(SHOW_CYC + 1) > dmsr_pkg::DIM_W ?
        $clog2(SHOW_CYC + 1) : dmsr_pkg::DIM_W;
    localparam int DW = $clog2(HALF + 1);
    localparam logic [AW-1:0] CH_LAST = AW'(CHARS - 1);
    localparam logic [DW-1:0] HALF_CNT = DW'(HALF - 1);
    localparam logic [TW-1:0] SHOW_CNT = TW'(SHOW_CYC - 1);
    localparam logic [2:0] COL_LAST_C = dmsr_pkg::COL_LAST;
    // Whole refresh must fit the flicker limit
    localparam bit REFRESH_OK =
        5 * LOAD_M * LOAD_CYC <= dmsr_pkg::REFRESH_CYC_MAX;

    typedef struct packed {
        dmsr_pkg::dmsr_state_e st;
        logic [DW-1:0] div;
        logic sclk;
        logic sdi;
        logic blank_n;
        logic [4:0] col;
        logic [2:0] cidx;
        logic [AW-1:0] ch;
        logic [2:0] row;
        logic [TW-1:0] tmr;
    } dmsr_ctrl_s;
    dmsr_ctrl_s q, d;

    logic [dmsr_pkg::CODE_W-1:0] sym_mem [CHARS];
    logic [dmsr_pkg::COLS-1:0] font_mem [dmsr_pkg::FONT_DEPTH*8];
    logic f_valid, f_ready;
    logic [FW-1:0] f_data;
    logic [dmsr_pkg::COLS-1:0] row_bits;

    function automatic logic [4:0] col_onehot(input logic [2:0] idx);
        col_onehot = 5'h01 << idx;
    endfunction

    function automatic logic [9:0] font_index(
        input logic [dmsr_pkg::CODE_W-1:0] code,
        input logic [2:0] row);
        font_index = {code, row};
    endfunction

    // Symbol store is not touched mid-load, so the FIFO fills then
    dmsr_fifo #(
        .WIDTH(FW),
        .DEPTH(dmsr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .in_valid_in(sym_valid_in),
        .in_ready_out(sym_ready_out),
        .in_data_in({sym_addr_in, sym_code_in}),
        .out_valid_out(f_valid),
        .out_ready_in(f_ready),
        .out_data_out(f_data)
    );
    assign f_ready = (q.st != dmsr_pkg::DMSR_LOAD);

    // Cleared on reset so the first load reads the code 0 font rows, never an unknown symbol
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            for (int i = 0; i < CHARS; i++)
                sym_mem[i] <= '0;
        end
        else if (ce_in & f_valid & f_ready)
            sym_mem[f_data[FW-1:dmsr_pkg::CODE_W]] <=
                f_data[dmsr_pkg::CODE_W-1:0];
    end

    always_ff @(posedge clk_in)
    begin
        if (ce_in & font_wr_in)
            font_mem[font_index(font_code_in, font_row_in)] <=
                font_bits_in;
    end

    // Code plus row gives all five column bits of that row
    assign row_bits = font_mem[font_index(sym_mem[q.ch], q.row)];

    always_comb
    begin
        d = q;
        unique case (q.st)
            dmsr_pkg::DMSR_LOAD:
            begin
                d.blank_n = 1'b0;
                d.col = 5'h00;
                if (q.div != '0)
                    d.div = q.div - 1'b1;
                else if (!q.sclk)
                begin
                    // New bit goes out with the rising edge
                    d.sdi = row_bits[q.cidx];
                    d.sclk = 1'b1;
                    d.div = HALF_CNT;
                end
                else
                begin
                    // Falling edge: display takes the bit now
                    d.sclk = 1'b0;
                    d.div = HALF_CNT;
                    if (q.row != '0)
                        d.row = q.row - 1'b1;
                    else
                    begin
                        d.row = dmsr_pkg::ROW_TOP;
                        if (q.ch != '0)
                            d.ch = q.ch - 1'b1;
                        else
                        begin
                            // Full load done, light the column
                            d.ch = CH_LAST;
                            d.st = dmsr_pkg::DMSR_SHOW;
                            d.tmr = SHOW_CNT;
                        end
                    end
                end
            end
            dmsr_pkg::DMSR_SHOW:
            begin
                d.blank_n = 1'b1;
                d.col = col_onehot(q.cidx);
                if (q.tmr != '0)
                    d.tmr = q.tmr - 1'b1;
                else
                begin
                    // Current off in the same cycle the column index moves
                    d.blank_n = 1'b0;
                    d.col = 5'h00;
                    d.cidx = (q.cidx == COL_LAST_C) ? 3'h0 :
                        q.cidx + 3'h1;
                    d.div = '0;
                    if (dim_cycles_in != '0)
                    begin
                        d.st = dmsr_pkg::DMSR_DIM;
                        d.tmr = TW'(dim_cycles_in);
                    end
                    else
                        d.st = dmsr_pkg::DMSR_LOAD;
                end
            end
            dmsr_pkg::DMSR_DIM:
            begin
                // Longer dim stretches refresh; keep it within flicker limit
                d.blank_n = 1'b0;
                d.col = 5'h00;
                if (q.tmr > TW'(1))
                    d.tmr = q.tmr - 1'b1;
                else
                    d.st = dmsr_pkg::DMSR_LOAD;
            end
            default:
            begin
                d.st = dmsr_pkg::DMSR_LOAD;
                d.blank_n = 1'b0;
                d.col = 5'h00;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            q <= '0;
            q.st <= dmsr_pkg::DMSR_LOAD;
            q.ch <= CH_LAST;
            q.row <= dmsr_pkg::ROW_TOP;
        end
        else if (ce_in)
            q <= d;
    end

    assign link.sclk = q.sclk;
    assign link.sdi = q.sdi;
    assign link.blank_n = q.blank_n;
    assign link.col = q.col;
    assign loading_out = (q.st == dmsr_pkg::DMSR_LOAD);
    assign column_out = q.cidx;
endmodule

// [test/dmsr_link_checker.sv]
`timescale 1ns/100ps
module dmsr_link_checker #(
    parameter int SHOW = 224
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Link
    input wire logic sclk,
    input wire logic sdi,
    input wire logic blank_n,
    input wire logic [4:0] col,
    input wire logic sdo
);
    logic sclk_q;
    logic first_q;
    logic [4:0] prev_q;
    logic [5:0] falls_q;
    logic [15:0] show_q;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    // Reset to column five so the first show must be column one
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            sclk_q <= 1'b0;
            first_q <= 1'b0;
            prev_q <= 5'h10;
            falls_q <= 6'h00;
            show_q <= 16'h0000;
        end
        else
        begin
            sclk_q <= sclk;
            show_q <= blank_n ? show_q + 16'h0001 : 16'h0000;
            if (col != 5'h00)
                prev_q <= col;
            if (blank_n)
                falls_q <= 6'h00;
            else if (sclk_q && !sclk)
                falls_q <= falls_q + 6'h01;
            if (!blank_n && falls_q == 6'h00 && sclk && !sclk_q)
                first_q <= sdi;
        end
    end
    a_quiet_shifting: assert property (
        sclk |-> !blank_n && col == 5'h00)
        else $error("column current on while shifting");
    a_one_column: assert property ($onehot0(col))
        else $error("more than one column driver on");
    a_blank_with_col: assert property (blank_n == (col != 5'h00))
        else $error("column and blanking out of step");
    a_clock_high: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("shift clock high time wrong");
    a_clock_low: assert property ($fell(sclk) |-> !sclk[*4])
        else $error("shift clock low time wrong");
    a_data_steady: assert property (
        sclk && !$rose(sclk) |-> $stable(sdi))
        else $error("serial data moved near falling edge");
    a_full_load: assert property ($rose(blank_n) |-> falls_q == 6'h1C)
        else $error("load did not shift 28 bits");
    a_next_column: assert property (col != 5'h00 && col != prev_q
        |-> col == {prev_q[3:0], prev_q[4]})
        else $error("column did not step by one");
    a_serial_out: assert property (
        $rose(blank_n) |-> ##3 sdo == first_q)
        else $error("serial out is not the first bit loaded");
    a_show_time: assert property ($fell(blank_n)
        |-> show_q >= SHOW - 1 && show_q <= SHOW + 1)
        else $error("show time wrong");
endmodule

// [test/dot_matrix_string_refresh_tb.sv]
`timescale 1ns/100ps
module dot_matrix_string_refresh_tb;
    localparam int M = 2;
    logic clk_in, reset_in, sym_valid_in, sym_ready_out, font_wr_in;
    logic loading_out, blank_w;
    logic [1:0] sym_addr_in;
    logic [6:0] sym_code_in, font_code_in;
    logic [2:0] font_row_in, column_out;
    logic [4:0] font_bits_in;
    logic [15:0] dim_cycles_in;
    logic [27:0] row_sink_out;
    logic [139:0] led_out;
    logic [4:0] font_m [128][7];
    logic [6:0] sym_m [4];
    logic [6:0] codes [20];
    logic [31:0] seed;
    int num_errors, num_checks, taken, gap;
    dmsr_link_if dmsr_link_if_inst();
    assign blank_w = dmsr_link_if_inst.blank_n;
    dmsr_ctrl #(.CHARS(4), .LOAD_M(M), .HALF(4)) dmsr_ctrl_inst (
        .clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1),
        .sym_valid_in(sym_valid_in), .sym_ready_out(sym_ready_out),
        .sym_addr_in(sym_addr_in), .sym_code_in(sym_code_in),
        .font_wr_in(font_wr_in), .font_code_in(font_code_in),
        .font_row_in(font_row_in), .font_bits_in(font_bits_in),
        .dim_cycles_in(dim_cycles_in), .loading_out(loading_out),
        .column_out(column_out), .link(dmsr_link_if_inst));
    dmsr_display #(.PACKAGES(1)) dmsr_display_inst (
        .clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1),
        .link(dmsr_link_if_inst), .row_sink_out(row_sink_out),
        .led_out(led_out));
    dmsr_link_checker #(.SHOW((M - 1) * 224)) dmsr_link_checker_inst (
        .clk_in(clk_in), .reset_in(reset_in),
        .sclk(dmsr_link_if_inst.sclk), .sdi(dmsr_link_if_inst.sdi),
        .blank_n(dmsr_link_if_inst.blank_n), .col(dmsr_link_if_inst.col),
        .sdo(dmsr_link_if_inst.sdo));
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [27:0] exp_rows(input int k);
        logic [27:0] r;
        for (int i = 0; i < 28; i++)
            r[i] = font_m[sym_m[i / 7]][i % 7][k];
        return r;
    endfunction
    function automatic logic [139:0] exp_leds(input int k);
        logic [139:0] l;
        logic [27:0] r;
        l = '0;
        r = exp_rows(k);
        for (int i = 0; i < 28; i++)
            l[(i / 7) * 35 + k * 7 + i % 7] = r[i];
        return l;
    endfunction
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [139:0] got, input logic [139:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded so a stuck link ends the run instead of hanging it
    task automatic wait_for(input bit blank, input logic v);
        int n;
        n = 0;
        while ((blank ? blank_w : loading_out) !== v && n < 20000)
        begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 20000)
        begin
            num_errors++;
            report_and_stop();
        end
    endtask
    task automatic scan(input int n, input bit cmp);
        repeat (n)
        begin
            wait_for(1, 1'b0);
            wait_for(1, 1'b1);
            repeat (8) @(negedge clk_in);
            if (cmp)
            begin
                check(140'(row_sink_out),
                    140'(exp_rows(column_out)));
                check(led_out, exp_leds(column_out));
                check(140'(dmsr_link_if_inst.col),
                    140'(5'h01 << column_out));
            end
        end
        $display("scan of %0d columns done", n);
    endtask
    initial
    begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial
    begin
        {sym_valid_in, font_wr_in, sym_addr_in, sym_code_in} = '0;
        {font_code_in, font_row_in, font_bits_in, dim_cycles_in} = '0;
        {num_errors, num_checks} = '0;
        reset_in = 1'b1;
        seed = 32'h00006ABC;
        // Code 0 rows land under reset, so cleared symbols shift known dots
        for (int c = 0; c < 128; c++)
            for (int r = 0; r < 7; r++)
            begin
                seed = xorshift(seed);
                font_m[c][r] = seed[4:0];
                @(posedge clk_in);
                font_wr_in <= 1'b1;
                font_code_in <= c[6:0];
                font_row_in <= r[2:0];
                font_bits_in <= seed[4:0];
                if (c * 7 + r == 19)
                    reset_in <= 1'b0;
            end
        @(posedge clk_in);
        font_wr_in <= 1'b0;
        for (int i = 0; i < 20; i++)
        begin
            seed = xorshift(seed);
            codes[i] = seed[6:0];
        end
        codes[12] = 7'h00;
        codes[15] = 7'h7F;
        $display("font written");
        // Drain stalls while loading, so 16 back-to-back pushes fill it
        wait_for(0, 1'b0);
        wait_for(0, 1'b1);
        taken = 0;
        repeat (20)
        begin
            @(posedge clk_in);
            sym_valid_in <= 1'b1;
            sym_addr_in <= taken[1:0];
            sym_code_in <= codes[taken];
            @(negedge clk_in);
            if (sym_ready_out === 1'b1)
                taken++;
        end
        check({132'h0, taken[7:0]}, {132'h0, 8'h10});
        check({139'h0, sym_ready_out}, 140'h0);
        check(led_out, 140'h0);
        @(posedge clk_in);
        sym_valid_in <= 1'b0;
        for (int a = 0; a < 4; a++)
            sym_m[a] = codes[12 + a];
        $display("buffer fill done");
        scan(10, 0);
        scan(10, 1);
        seed = xorshift(seed);
        @(posedge clk_in);
        dim_cycles_in <= {8'h00, seed[7:0]};
        scan(2, 0);
        wait_for(1, 1'b0);
        gap = 0;
        while (blank_w === 1'b0 && gap < 2000)
        begin
            @(negedge clk_in);
            gap++;
        end
        // Blanked stretch is the dim count plus one load of 28 bits
        check(140'(gap >= seed[7:0] + 220 && gap <= seed[7:0] + 224),
            140'h1);
        scan(10, 1);
        $display("dimming done");
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (3) @(negedge clk_in);
        check({134'h0, blank_w, dmsr_link_if_inst.col}, 140'h0);
        @(posedge clk_in);
        reset_in <= 1'b0;
        // Reset clears the symbol store to code 0
        for (int a = 0; a < 4; a++)
            sym_m[a] = 7'h00;
        scan(5, 1);
        $display("second reset done");
        report_and_stop();
    end
endmodule
